// ===== pkg/cdu_pkg.sv
// Package with register map, field layout and types for the current DAC update scheduler
package cdu_pkg;
    // Register addresses on the special-function register port
    localparam logic [7:0] ADDR_DAC_CONTROL = 8'hb9;
    localparam logic [7:0] ADDR_DATA_HIGH   = 8'h97;
    localparam logic [7:0] ADDR_DATA_LOW    = 8'h96;

    // Control field positions
    localparam int EN_BIT   = 7;
    localparam int SRC_MSB  = 6;
    localparam int SRC_LSB  = 4;
    localparam int FS_MSB   = 1;
    localparam int FS_LSB   = 0;
    localparam int LOW_MSB  = 7;
    localparam int LOW_LSB  = 6;

    // Reset values and read masks
    localparam logic [7:0] CONTROL_RESET = 8'h72;
    localparam logic [7:0] CONTROL_MASK  = 8'hf3;
    localparam logic [7:0] HIGH_RESET    = 8'h00;
    localparam logic [7:0] LOW_RESET     = 8'h00;
    localparam logic [7:0] LOW_MASK      = 8'hc0;

    // Full-scale currents in microamps
    localparam logic [11:0] FS_HALF_UA = 12'h1f4;
    localparam logic [11:0] FS_ONE_UA  = 12'h3e8;
    localparam logic [11:0] FS_TWO_UA  = 12'h7d0;

    // Update source encodings
    typedef enum logic [2:0] {
        SRC_TIMER0  = 3'h0,
        SRC_TIMER1  = 3'h1,
        SRC_TIMER2  = 3'h2,
        SRC_TIMER3  = 3'h3,
        SRC_RISE    = 3'h4,
        SRC_FALL    = 3'h5,
        SRC_ANYEDGE = 3'h6,
        SRC_ONWRITE = 3'h7
    } cdu_src_t;

    // Register read and write request bundle
    typedef struct packed {
        logic       wrEn;
        logic       rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cdu_regreq_t;

    // Converter drive bundle
    typedef struct packed {
        logic        enable;
        logic        biasOn;
        logic [1:0]  fullscale;
        logic [9:0]  code;
    } cdu_analog_t;
endpackage : cdu_pkg

// ===== rtl/cdu_current_dac_update_scheduler.sv
// Special-function register control and update scheduling for a 10-bit current DAC
`timescale 1ns/10ps
module cdu_current_dac_update_scheduler #(
    parameter int WORD_W = 10
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire cdu_pkg::cdu_regreq_t regReq,
    output logic [7:0]                regRdata,
    input  wire logic [3:0]           timerOverflow,
    input  wire logic                 conversionStrobeInput,
    output cdu_pkg::cdu_analog_t      analogCtl,
    output logic [21:0]               outCurrentNa,
    output logic                      pinDigitalDriverEn,
    output logic                      pinPullupEn,
    output logic                      pinAnalogConnect,
    output logic [WORD_W-1:0]         stagedWord
);
    // Elaboration check: the byte mapping only serves a 10-bit word
    if (WORD_W != 10) begin : g_bad_width
        $error("WORD_W must be 10");
    end

    logic [7:0]        dacControl;
    logic [7:0]        dataHigh;
    logic [7:0]        dataLow;
    logic [WORD_W-1:0] latchWord;
    logic              strobeMeta;
    logic              strobeSync;
    logic              strobeLast;

    // Address decode for the register port
    wire selCtl  = regReq.addr == cdu_pkg::ADDR_DAC_CONTROL;
    wire selHigh = regReq.addr == cdu_pkg::ADDR_DATA_HIGH;
    wire selLow  = regReq.addr == cdu_pkg::ADDR_DATA_LOW;
    wire wrCtl   = regReq.wrEn & selCtl;
    wire wrHigh  = regReq.wrEn & selHigh;
    wire wrLow   = regReq.wrEn & selLow;

    // Control fields
    wire                     dacEnable = dacControl[cdu_pkg::EN_BIT];
    wire [2:0]               srcBits   = dacControl[cdu_pkg::SRC_MSB:cdu_pkg::SRC_LSB];
    wire cdu_pkg::cdu_src_t  srcSel    = cdu_pkg::cdu_src_t'(srcBits);
    wire [1:0]               fsSel     = dacControl[cdu_pkg::FS_MSB:cdu_pkg::FS_LSB];

    // Staged word is left-justified across the two bytes
    assign stagedWord = {dataHigh, dataLow[cdu_pkg::LOW_MSB:cdu_pkg::LOW_LSB]};

    // Edge detect only looks at the second synchroniser stage
    wire riseEdge = strobeSync & ~strobeLast;
    wire fallEdge = ~strobeSync & strobeLast;

    // Load pulse selection; low byte writes never load by themselves
    logic loadPulse;
    always_comb begin
        case (srcSel)
            cdu_pkg::SRC_TIMER0:  loadPulse = timerOverflow[0];
            cdu_pkg::SRC_TIMER1:  loadPulse = timerOverflow[1];
            cdu_pkg::SRC_TIMER2:  loadPulse = timerOverflow[2];
            cdu_pkg::SRC_TIMER3:  loadPulse = timerOverflow[3];
            cdu_pkg::SRC_RISE:    loadPulse = riseEdge;
            cdu_pkg::SRC_FALL:    loadPulse = fallEdge;
            cdu_pkg::SRC_ANYEDGE: loadPulse = riseEdge | fallEdge;
            cdu_pkg::SRC_ONWRITE: loadPulse = wrHigh;
            default:              loadPulse = 1'b0;
        endcase
    end

    // On-demand load must see the byte being written in the same cycle
    wire [WORD_W-1:0] loadWord = (srcSel == cdu_pkg::SRC_ONWRITE)
                               ? {regReq.wdata, dataLow[cdu_pkg::LOW_MSB:cdu_pkg::LOW_LSB]}
                               : stagedWord;

    // Register file
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            dacControl <= cdu_pkg::CONTROL_RESET;
            dataHigh   <= cdu_pkg::HIGH_RESET;
            dataLow    <= cdu_pkg::LOW_RESET;
        end else begin
            if (wrCtl)  dacControl <= regReq.wdata & cdu_pkg::CONTROL_MASK;
            if (wrHigh) dataHigh   <= regReq.wdata;
            if (wrLow)  dataLow    <= regReq.wdata & cdu_pkg::LOW_MASK;
        end
    end

    // Strobe synchroniser and converter input latch
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            strobeMeta <= 1'b0;
            strobeSync <= 1'b0;
            strobeLast <= 1'b0;
            latchWord  <= '0;
        end else begin
            strobeMeta <= conversionStrobeInput;
            strobeSync <= strobeMeta;
            strobeLast <= strobeSync;
            if (loadPulse) latchWord <= loadWord;
        end
    end

    // Read mux; unused bits read zero, unmapped reads zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 8'h00;
        end else if (regReq.rdEn) begin
            regRdata <= selCtl ? dacControl : selHigh ? dataHigh : selLow ? dataLow : 8'h00;
        end
    end

    // Full-scale selection, 1x means 2 mA
    wire [11:0] fsUa = fsSel[1] ? cdu_pkg::FS_TWO_UA
                     : fsSel[0] ? cdu_pkg::FS_ONE_UA
                     : cdu_pkg::FS_HALF_UA;

    // Ideal current: code times full-scale over 1024, in nanoamps; kept for model checks
    wire [31:0] prodNa = 32'(latchWord) * 32'(fsUa) * 32'h3e8;
    assign outCurrentNa = dacEnable ? prodNa[31:10] : 22'h000000;

    // Pin takeover and bias follow the enable directly
    assign pinDigitalDriverEn = ~dacEnable;
    assign pinPullupEn        = ~dacEnable;
    assign pinAnalogConnect   = dacEnable;
    assign analogCtl.enable    = dacEnable;
    assign analogCtl.biasOn    = dacEnable;
    assign analogCtl.fullscale = fsSel;
    assign analogCtl.code      = latchWord;

    // Checks
    chk_write_loads: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_ONWRITE && wrHigh) |=> latchWord == $past(loadWord))
        else $error("high byte write did not load latch");
    chk_low_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        (wrLow && !loadPulse) |=> $stable(latchWord))
        else $error("low byte write changed output");
    chk_timer_loads: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcBits[2] == 1'b0 && timerOverflow[srcBits[1:0]]) |=> latchWord == $past(stagedWord))
        else $error("timer overflow did not load");
    chk_timer_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcBits[2] == 1'b0 && !timerOverflow[srcBits[1:0]]) |=> $stable(latchWord))
        else $error("latch moved without overflow");
    chk_rise_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_RISE && !strobeSync ##1 srcSel == cdu_pkg::SRC_RISE
         && strobeSync) |=> latchWord == $past(stagedWord))
        else $error("rising strobe edge missed");
    chk_fall_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_FALL && !fallEdge) |=> $stable(latchWord))
        else $error("falling mode loaded without edge");
    chk_pin_takeover: assert property (@(posedge clk_sys) disable iff (!rstn)
        dacEnable |-> (!pinDigitalDriverEn && !pinPullupEn && pinAnalogConnect
                       && analogCtl.biasOn))
        else $error("pin not handed to converter");
    chk_zero_current: assert property (@(posedge clk_sys) disable iff (!rstn)
        (latchWord == '0) |-> outCurrentNa == 22'h000000)
        else $error("zero code gave current");
    chk_fs_two: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dacEnable && fsSel[1] && latchWord == 10'h200) |-> outCurrentNa == 22'h0f4240)
        else $error("2 mA full scale wrong");

    // Half-scale code under the two smaller settings
    chk_fs_one: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dacEnable && fsSel == 2'b01 && latchWord == 10'h200) |-> outCurrentNa == 22'h07a120)
        else $error("1 mA full scale wrong");
    chk_fs_half: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dacEnable && fsSel == 2'b00 && latchWord == 10'h200) |-> outCurrentNa == 22'h03d090)
        else $error("0.5 mA full scale wrong");

    // Disabled converter drives no current at all
    chk_disabled_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        !dacEnable |-> outCurrentNa == 22'h000000)
        else $error("current while disabled");

    // Pin stays an ordinary port pin while disabled
    chk_gpio_mode: assert property (@(posedge clk_sys) disable iff (!rstn)
        !dacEnable |-> (pinDigitalDriverEn && pinPullupEn && !pinAnalogConnect
                        && !analogCtl.biasOn))
        else $error("pin taken while disabled");

    // Falling and either-edge modes copy the staged word
    chk_fall_loads: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_FALL && fallEdge) |=> latchWord == $past(stagedWord))
        else $error("falling strobe edge missed");
    chk_any_edge: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_ANYEDGE && (riseEdge || fallEdge))
        |=> latchWord == $past(stagedWord))
        else $error("strobe edge missed in any-edge mode");
    chk_rise_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_RISE && !riseEdge) |=> $stable(latchWord))
        else $error("rising mode loaded without edge");

    // Each qualifying edge gives a single-cycle pulse
    chk_rise_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        riseEdge |=> !riseEdge)
        else $error("rising edge pulse too long");
    chk_fall_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
        fallEdge |=> !fallEdge)
        else $error("falling edge pulse too long");

    // On-demand mode moves the latch only on a high byte write
    chk_ondemand_held: assert property (@(posedge clk_sys) disable iff (!rstn)
        (srcSel == cdu_pkg::SRC_ONWRITE && !wrHigh) |=> $stable(latchWord))
        else $error("on-demand latch moved without high write");

    // Control readback and unused bits
    chk_read_ctl: assert property (@(posedge clk_sys) disable iff (!rstn)
        (regReq.rdEn && selCtl) |=> regRdata == $past(dacControl))
        else $error("control readback wrong");
    chk_ctl_unused: assert property (@(posedge clk_sys) disable iff (!rstn)
        (dacControl & ~cdu_pkg::CONTROL_MASK) == 8'h00)
        else $error("unused control bits set");

    cov_ondemand: cover property (@(posedge clk_sys) disable iff (!rstn)
        srcSel == cdu_pkg::SRC_ONWRITE && wrLow ##[1:4] wrHigh);
    cov_timer3: cover property (@(posedge clk_sys) disable iff (!rstn)
        srcSel == cdu_pkg::SRC_TIMER3 && timerOverflow[3]);
    cov_anyedge: cover property (@(posedge clk_sys) disable iff (!rstn)
        srcSel == cdu_pkg::SRC_ANYEDGE && fallEdge);
    cov_rise_load: cover property (@(posedge clk_sys) disable iff (!rstn)
        srcSel == cdu_pkg::SRC_RISE && riseEdge);
    cov_fall_load: cover property (@(posedge clk_sys) disable iff (!rstn)
        srcSel == cdu_pkg::SRC_FALL && fallEdge);
endmodule : cdu_current_dac_update_scheduler

// ===== sim/current_dac_update_scheduler_test.sv
// Self-checking bench for the current DAC update scheduler
`timescale 1ns/10ps
module current_dac_update_scheduler_test;
    logic                 clk_sys;
    logic                 rstn;
    cdu_pkg::cdu_regreq_t regReq;
    logic [7:0]           regRdata;
    logic [3:0]           timerOverflow;
    logic                 strobe;
    cdu_pkg::cdu_analog_t analogCtl;
    logic [21:0]          outCurrentNa;
    logic                 pinDrv;
    logic                 pinPull;
    logic                 pinAna;
    logic [9:0]           stagedWord;
    logic [9:0]           prev;
    logic [7:0]           rv;
    int                   n_fail;
    int                   total_checks;

    cdu_current_dac_update_scheduler uut (.clk_sys(clk_sys), .rstn(rstn), .regReq(regReq),
        .regRdata(regRdata), .timerOverflow(timerOverflow), .conversionStrobeInput(strobe),
        .analogCtl(analogCtl), .outCurrentNa(outCurrentNa), .pinDigitalDriverEn(pinDrv),
        .pinPullupEn(pinPull), .pinAnalogConnect(pinAna), .stagedWord(stagedWord));

    // Free-running 125 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    // Bus strobes are driven 1 ns after the edge so the design samples them cleanly
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1 regReq = '{1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        #1 regReq = '0;
    endtask : wr

    // Extra edge before sampling tolerates either read latency reading
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        #1 regReq = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys);
        #1 regReq = '0;
        @(posedge clk_sys);
        #1 check(regRdata, exp);
    endtask : rd

    task automatic tmr(input int n);
        @(posedge clk_sys);
        #1 timerOverflow = 4'h1 << n;
        @(posedge clk_sys);
        #1 timerOverflow = 4'h0;
    endtask : tmr

    // Waits for a load with a bound; without a load it watches the full window
    task automatic settle(input logic [9:0] exp, input logic load);
        int i;
        for (i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            #1;
            if (load && analogCtl.code === exp) break;
        end
        check(analogCtl.code, exp);
        if (load && i == 8) end_sim();
    endtask : settle

    task automatic t_reset;
        rd(cdu_pkg::ADDR_DAC_CONTROL, 8'h72);
        rd(cdu_pkg::ADDR_DATA_HIGH, 8'h00);
        rd(cdu_pkg::ADDR_DATA_LOW, 8'h00);
        rd(8'h00, 8'h00);
        check({pinDrv, pinPull, pinAna, analogCtl.biasOn}, 4'hc);
        check({analogCtl.enable, analogCtl.fullscale}, 3'h2);
        check(outCurrentNa, 32'h0);
        $display("reset test done");
    endtask : t_reset

    task automatic t_ondemand;
        wr(cdu_pkg::ADDR_DAC_CONTROL, 8'hfc); // Port skip is set outside this block
        wr(8'h00, 8'h55);
        rd(cdu_pkg::ADDR_DAC_CONTROL, 8'hf0);
        check({pinDrv, pinPull, pinAna, analogCtl.biasOn}, 4'h3);
        wr(cdu_pkg::ADDR_DATA_LOW, 8'hff); // Low byte first
        check(analogCtl.code, 10'h000);
        rd(cdu_pkg::ADDR_DATA_LOW, 8'hc0);
        wr(cdu_pkg::ADDR_DATA_HIGH, 8'h80); // High byte second
        check(analogCtl.code, 10'h203);
        wr(cdu_pkg::ADDR_DATA_LOW, 8'h00); // Eight-bit use: low byte set once
        wr(cdu_pkg::ADDR_DATA_HIGH, 8'h80);
        check(analogCtl.code, 10'h200);
        for (int fs = 0; fs < 4; fs++) begin
            wr(cdu_pkg::ADDR_DAC_CONTROL, 8'hf0 | fs[7:0]);
            check(analogCtl.fullscale, fs[1:0]);
            check(outCurrentNa, fs == 0 ? 250000 : fs == 1 ? 500000 : 1000000);
        end
        wr(cdu_pkg::ADDR_DAC_CONTROL, 8'h72);
        check({pinDrv, pinPull, pinAna, outCurrentNa}, {3'h6, 22'h0});
        $display("on-demand test done");
    endtask : t_ondemand

    task automatic t_timer;
        prev = 10'h200;
        for (int n = 0; n < 4; n++) begin
            wr(cdu_pkg::ADDR_DAC_CONTROL, 8'h82 | (n[7:0] << 4));
            wr(cdu_pkg::ADDR_DATA_LOW, {n[1:0], 6'h00});
            wr(cdu_pkg::ADDR_DATA_HIGH, 8'h10 + n[7:0]);
            check(stagedWord, {8'h10 + n[7:0], n[1:0]});
            tmr((n + 1) % 4);
            check(analogCtl.code, prev);
            tmr(n);
            prev = {8'h10 + n[7:0], n[1:0]};
            check(analogCtl.code, prev);
        end
        $display("timer test done");
    endtask : t_timer

    // Each strobe mode sees one rising and one falling edge
    task automatic t_strobe;
        logic load;
        // Low bits left over from the timer test would leak into the word
        wr(cdu_pkg::ADDR_DATA_LOW, 8'h00);
        for (int m = 4; m < 7; m++) begin
            wr(cdu_pkg::ADDR_DAC_CONTROL, 8'h82 | (m[7:0] << 4));
            for (int e = 1; e >= 0; e--) begin
                wr(cdu_pkg::ADDR_DATA_HIGH, {1'b0, m[2:0], 3'h0, e[0]});
                load = (m == 4 && e == 1) || (m == 5 && e == 0) || m == 6;
                @(posedge clk_sys);
                #1 strobe = e[0];
                if (load) prev = {1'b0, m[2:0], 3'h0, e[0], 2'h0};
                settle(prev, load);
            end
        end
        $display("strobe test done");
    endtask : t_strobe

    // Main sequence
    initial begin
        n_fail = 0;
        total_checks = 0;
        rstn = 1'b0;
        regReq = '0;
        timerOverflow = 4'h0;
        strobe = 1'b0;
        repeat (10) @(posedge clk_sys);
        #1 rstn = 1'b1;
        t_reset();
        t_ondemand();
        t_timer();
        t_strobe();
        end_sim();
    end
endmodule : current_dac_update_scheduler_test
